// >>> src/cfeg_defs.svh
`ifndef CFEG_DEFS_SVH
`define CFEG_DEFS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CFEG_OFS_CTRL      8'h00
`define CFEG_OFS_CYCLE     8'h04
`define CFEG_OFS_STATUS    8'h08
`define CFEG_OFS_DATA      8'h0c

// ----------------------------------------
// field positions
// ----------------------------------------
`define CFEG_CTRL_RUN      0
`define CFEG_CTRL_SYNC     1
`define CFEG_CTRL_MODE32   2
`define CFEG_CTRL_CLEAR    8
`define CFEG_ST_LINK       0
`define CFEG_ST_SYNC       1
`define CFEG_ST_CYC_ALM    2
`define CFEG_ST_DAT_ALM    3
`define CFEG_ST_LED        4
`define CFEG_CR_BIT        7
`define CFEG_SUBCHK_BIT    7
`define CFEG_SUBCHK_BYTE   6'h10

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define CFEG_CYCLE_RST     24'h01e848
`define CFEG_CLK_NS        8
`define CFEG_TOL_NS        2000
`define CFEG_TOL_CYC       (`CFEG_TOL_NS / `CFEG_CLK_NS)
`define CFEG_BLINK_MS      250
`define CFEG_BLINK_CYC     ((`CFEG_BLINK_MS * 1000000) / `CFEG_CLK_NS)
`define CFEG_SUBCHK_LIMIT  4'h8

`endif

// >>> src/cfeg_pkg.sv
package cfeg_pkg;

    typedef enum logic [0:0] {
        CFEG_INITIAL = 1'b0,
        CFEG_LINK_ACTIVE_STATE = 1'b1
    } cfeg_link_e;

    typedef struct packed {
        logic [5:0]  cnt;
        logic        id_bad;
        logic        cr_bad;
        logic        sub_one;
        logic [31:0] word;
        logic        done;
        logic        r_id;
        logic        r_cr;
        logic        r_sub0;
    } cfeg_chk_s;

    typedef struct packed {
        logic        irq_s1;
        logic        irq_s2;
        logic        irq_s3;
        logic [4:0]  sid_s1;
        logic [4:0]  sid_s2;
        cfeg_link_e  link;
        logic        synced;
        logic        mode32;
        logic [23:0] cycle_set;
        logic [23:0] cyc_cnt;
        logic        seen_irq;
        logic        cyc_alarm;
        logic        dat_alarm;
        logic [3:0]  sub_cnt;
        logic        pend_valid;
        logic [31:0] pend_word;
        logic [31:0] cmd_word;
        logic        dp_wr;
        logic [7:0]  dp_addr;
        logic [31:0] hrdata;
        logic        hreadyout;
        logic [24:0] blink_cnt;
        logic        blink;
        logic        led_red;
    } cfeg_top_s;

endpackage

// >>> src/cfeg_frame_check.sv
`timescale 1ns/100ps
`default_nettype none
`include "cfeg_defs.svh"

module cfeg_frame_check
    import cfeg_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // received byte stream
    input  wire logic        rx_sof,
    input  wire logic        rx_valid,
    input  wire logic        rx_eof,
    input  wire logic [7:0]  rx_byte,
    // settings
    input  wire logic [4:0]  station_identifier,
    input  wire logic        mode32,
    // frame verdict
    output var  logic        done,
    output var  logic        id_bad,
    output var  logic        cr_bad,
    output var  logic        sub_zero,
    output var  logic [31:0] word
);

    cfeg_chk_s q_ff;
    cfeg_chk_s nxt_q;

    always_comb begin
        logic [5:0] idx;
        idx = rx_sof ? 6'h00 : q_ff.cnt;
        nxt_q = q_ff;
        nxt_q.done = 1'b0;
        if (rx_valid) begin
            if (rx_sof) begin
                nxt_q.id_bad  = 1'b0;
                nxt_q.cr_bad  = 1'b0;
                nxt_q.sub_one = 1'b0;
            end
            // saturate so an overlong frame cannot wrap onto byte 0
            nxt_q.cnt = (idx == 6'h3f) ? idx : idx + 6'h01;
            if (idx == 6'h00) begin
                nxt_q.id_bad = (rx_byte[4:0] != station_identifier);
                nxt_q.cr_bad = rx_byte[`CFEG_CR_BIT];
            end
            if (idx < 6'h04) begin
                nxt_q.word[{idx[1:0], 3'b000} +: 8] = rx_byte;
            end
            if (idx == `CFEG_SUBCHK_BYTE) begin
                nxt_q.sub_one = rx_byte[`CFEG_SUBCHK_BIT];
            end
            if (rx_eof) begin
                nxt_q.done   = 1'b1;
                nxt_q.r_id   = nxt_q.id_bad;
                nxt_q.r_cr   = nxt_q.cr_bad;
                // a short frame in 32-byte mode counts as a cleared sub-check
                nxt_q.r_sub0 = mode32 & ~nxt_q.sub_one;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign done     = q_ff.done;
    assign id_bad   = q_ff.r_id;
    assign cr_bad   = q_ff.r_cr;
    assign sub_zero = q_ff.r_sub0;
    assign word     = q_ff.word;

endmodule // cfeg_frame_check
`default_nettype wire

// >>> src/cfeg_guard.sv
`timescale 1ns/100ps
`default_nettype none
`include "cfeg_defs.svh"

module cfeg_guard
    import cfeg_pkg::*;
#(
    parameter int unsigned BLINK_CYCLES = `CFEG_BLINK_CYC
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    // pins
    input  wire logic        rx_irq_start,
    input  wire logic [4:0]  station_identifier,
    // received byte stream from the network controller
    input  wire logic        rx_sof,
    input  wire logic        rx_valid,
    input  wire logic        rx_eof,
    input  wire logic [7:0]  rx_byte,
    // state towards the servo side
    output var  logic        link_active_state,
    output var  logic        link_synced,
    output var  logic        cycle_alarm,
    output var  logic        data_alarm,
    output var  logic [31:0] cmd_word,
    output var  logic        link_indicator
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // window is clipped at zero so a tiny cycle setting cannot underflow
    function automatic logic cycle_ok(input logic [23:0] cnt, input logic [23:0] set);
        logic [23:0] tol;
        logic [23:0] lo;
        tol = 24'(`CFEG_TOL_CYC);
        lo  = (set > tol) ? set - tol : 24'h000000;
        return (cnt >= lo) && ({1'b0, cnt} <= {1'b0, set} + {1'b0, tol});
    endfunction

    cfeg_top_s   q_ff;
    cfeg_top_s   nxt_q;
    logic        fc_done;
    logic        fc_id_bad;
    logic        fc_cr_bad;
    logic        fc_sub_zero;
    logic [31:0] fc_word;
    logic        irq_edge;
    logic        cyc_fault;
    logic        frame_bad;

    cfeg_frame_check u_check (
        .hclk               (hclk),
        .hresetn            (hresetn),
        .rx_sof             (rx_sof),
        .rx_valid           (rx_valid),
        .rx_eof             (rx_eof),
        .rx_byte            (rx_byte),
        .station_identifier (q_ff.sid_s2),
        .mode32             (q_ff.mode32),
        .done               (fc_done),
        .id_bad             (fc_id_bad),
        .cr_bad             (fc_cr_bad),
        .sub_zero           (fc_sub_zero),
        .word               (fc_word)
    );

    // s3 only delays s2, so the edge detect never reads the first synchroniser stage
    assign irq_edge  = q_ff.irq_s2 & ~q_ff.irq_s3;
    // the first interval after sync is skipped: its start point is unknown
    assign cyc_fault = irq_edge & (q_ff.link == CFEG_LINK_ACTIVE_STATE) & q_ff.synced & q_ff.seen_irq
                       & ~cycle_ok(q_ff.cyc_cnt, q_ff.cycle_set);
    assign frame_bad = fc_id_bad | fc_cr_bad;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic clr;
        clr   = 1'b0;
        nxt_q = q_ff;
        nxt_q.irq_s1 = rx_irq_start;
        nxt_q.irq_s2 = q_ff.irq_s1;
        nxt_q.irq_s3 = q_ff.irq_s2;
        nxt_q.sid_s1 = station_identifier;
        nxt_q.sid_s2 = q_ff.sid_s1;
        nxt_q.hreadyout = 1'b1;

        // register writes land in the data phase
        if (q_ff.dp_wr) begin
            if (q_ff.dp_addr == `CFEG_OFS_CTRL) begin
                clr = hwdata[`CFEG_CTRL_CLEAR];
                nxt_q.mode32 = hwdata[`CFEG_CTRL_MODE32];
                // a latched cycle alarm blocks restart until cleared
                if (hwdata[`CFEG_CTRL_RUN] && !q_ff.cyc_alarm) begin
                    nxt_q.link = CFEG_LINK_ACTIVE_STATE;
                end else if (!hwdata[`CFEG_CTRL_RUN]) begin
                    nxt_q.link   = CFEG_INITIAL;
                    nxt_q.synced = 1'b0;
                end
                if (hwdata[`CFEG_CTRL_SYNC] && nxt_q.link == CFEG_LINK_ACTIVE_STATE && !q_ff.synced) begin
                    nxt_q.synced   = 1'b1;
                    nxt_q.seen_irq = 1'b0;
                end else if (!hwdata[`CFEG_CTRL_SYNC]) begin
                    nxt_q.synced = 1'b0;
                end
            end else if (q_ff.dp_addr == `CFEG_OFS_CYCLE) begin
                nxt_q.cycle_set = hwdata[23:0];
            end
        end

        // cycle measurement between receive interrupts
        if (irq_edge) begin
            nxt_q.cyc_cnt  = 24'h000001;
            // an edge taken before sync does not arm the next check
            nxt_q.seen_irq = q_ff.synced;
            // commit pending data only on a regular interrupt
            if (!cyc_fault && q_ff.pend_valid) begin
                nxt_q.cmd_word   = q_ff.pend_word;
                nxt_q.pend_valid = 1'b0;
            end
        end else if (q_ff.cyc_cnt != 24'hffffff) begin
            nxt_q.cyc_cnt = q_ff.cyc_cnt + 24'h000001;
        end

        // clear first so that a same-cycle event wins
        if (clr) begin
            nxt_q.cyc_alarm = 1'b0;
            nxt_q.dat_alarm = 1'b0;
        end
        if (cyc_fault) begin
            nxt_q.cyc_alarm = 1'b1;
            nxt_q.link      = CFEG_INITIAL;
            nxt_q.synced    = 1'b0;
            nxt_q.seen_irq  = 1'b0;
        end

        // frame verdicts; bad frames never reach the pending buffer
        // good frames are kept even under a data alarm so a clear still gets through
        if (fc_done) begin
            if (frame_bad) begin
                nxt_q.dat_alarm = 1'b1;
            end else if (q_ff.link == CFEG_LINK_ACTIVE_STATE) begin
                nxt_q.pend_word  = fc_word;
                nxt_q.pend_valid = 1'b1;
            end
            if (!fc_sub_zero) begin
                nxt_q.sub_cnt = 4'h0;
            end else if (q_ff.sub_cnt == `CFEG_SUBCHK_LIMIT - 4'h1) begin
                nxt_q.dat_alarm = 1'b1;
                nxt_q.sub_cnt   = 4'h0;
            end else begin
                nxt_q.sub_cnt = q_ff.sub_cnt + 4'h1;
            end
        end

        // flash divider, one enable pulse per half period
        // free-link_active_state divider: the first flash after an alarm may be short
        if (q_ff.blink_cnt == 25'h0000000) begin
            nxt_q.blink_cnt = 25'(BLINK_CYCLES - 1);
            nxt_q.blink     = ~q_ff.blink;
        end else begin
            nxt_q.blink_cnt = q_ff.blink_cnt - 25'h0000001;
        end
        nxt_q.led_red = (nxt_q.cyc_alarm | nxt_q.dat_alarm) & nxt_q.blink;

        // address phase; read data reflects this cycle's write already
        nxt_q.dp_wr = 1'b0;
        if (hsel && hready && htrans[1]) begin
            nxt_q.dp_wr   = hwrite;
            nxt_q.dp_addr = haddr[7:0];
            if (!hwrite) begin
                if (haddr[7:0] == `CFEG_OFS_CTRL) begin
                    nxt_q.hrdata = {29'h0, nxt_q.mode32, nxt_q.synced, nxt_q.link == CFEG_LINK_ACTIVE_STATE};
                end else if (haddr[7:0] == `CFEG_OFS_CYCLE) begin
                    nxt_q.hrdata = {8'h00, nxt_q.cycle_set};
                end else if (haddr[7:0] == `CFEG_OFS_STATUS) begin
                    nxt_q.hrdata = {27'h0, nxt_q.led_red, nxt_q.dat_alarm, nxt_q.cyc_alarm,
                                    nxt_q.synced, nxt_q.link == CFEG_LINK_ACTIVE_STATE};
                end else if (haddr[7:0] == `CFEG_OFS_DATA) begin
                    nxt_q.hrdata = nxt_q.cmd_word;
                end else begin
                    nxt_q.hrdata = 32'h00000000;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q_ff           <= '0;
            q_ff.cycle_set <= `CFEG_CYCLE_RST;
            // the bus must be ready straight out of reset
            q_ff.hreadyout <= 1'b1;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign hrdata            = q_ff.hrdata;
    assign hreadyout         = q_ff.hreadyout;
    assign hresp             = 1'b0;
    assign link_active_state = (q_ff.link == CFEG_LINK_ACTIVE_STATE);
    assign link_synced       = q_ff.synced;
    assign cycle_alarm       = q_ff.cyc_alarm;
    assign data_alarm        = q_ff.dat_alarm;
    assign cmd_word          = q_ff.cmd_word;
    assign link_indicator    = q_ff.led_red;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_cycle_alarm_set: assert property (cyc_fault |=> q_ff.cyc_alarm)
        else $error("irregular interrupt did not raise cycle alarm");
    a_check_gating: assert property ($rose(q_ff.cyc_alarm) |->
        $past(q_ff.link == CFEG_LINK_ACTIVE_STATE && q_ff.synced))
        else $error("cycle alarm raised outside link_active_state synchronized link");
    a_check_at_irq: assert property ($rose(q_ff.cyc_alarm) |-> $past(irq_edge))
        else $error("cycle alarm raised without an interrupt edge");
    a_data_hold: assert property (!irq_edge |=> $stable(q_ff.cmd_word))
        else $error("command data changed between interrupts");
    a_link_drop: assert property (cyc_fault |=> !link_active_state ##1 !link_active_state)
        else $error("link not back in initial state after cycle alarm");
    a_sync_drop: assert property ($rose(q_ff.cyc_alarm) |-> !link_synced)
        else $error("synchronization kept after cycle alarm");
    a_cr_check: assert property (fc_done && fc_cr_bad |=> data_alarm)
        else $error("command/response bit set did not raise data alarm");
    a_id_check: assert property (fc_done && fc_id_bad |=> data_alarm)
        else $error("station identifier mismatch did not raise data alarm");
    a_subchk_limit: assert property (fc_done && fc_sub_zero && q_ff.sub_cnt == 4'h7 |=> data_alarm)
        else $error("sub-check run did not raise data alarm");
    a_bad_discard: assert property (fc_done && frame_bad |=>
        $stable(q_ff.pend_word) && $stable(link_active_state))
        else $error("bad frame data kept or link state changed");
    a_led_dark: assert property (!(cycle_alarm || data_alarm) && !$past(q_ff.dat_alarm) |=>
        !link_indicator || cycle_alarm || data_alarm)
        else $error("indicator lit without an alarm");
    // invariants that hold whatever the bus writes in the same cycle
    a_restart_block: assert property (q_ff.cyc_alarm && !link_active_state |=>
        !link_active_state)
        else $error("link restarted while cycle alarm latched");
    a_idle_no_check: assert property (!q_ff.synced && !q_ff.cyc_alarm |=>
        !q_ff.cyc_alarm)
        else $error("cycle alarm raised while not synchronized");
    a_sync_needs_run: assert property (link_synced |->
        link_active_state)
        else $error("synchronized without a link_active_state link");
    a_commit_regular: assert property (!$stable(q_ff.cmd_word) |->
        $past(irq_edge) && !$past(cyc_fault))
        else $error("command data changed outside a regular interrupt");
    a_clear_cycle: assert property (q_ff.dp_wr && q_ff.dp_addr == `CFEG_OFS_CTRL &&
        hwdata[`CFEG_CTRL_CLEAR] && !cyc_fault |=> !cycle_alarm)
        else $error("clear did not drop cycle alarm");
    a_clear_data: assert property (q_ff.dp_wr && q_ff.dp_addr == `CFEG_OFS_CTRL &&
        hwdata[`CFEG_CTRL_CLEAR] && !fc_done |=> !data_alarm)
        else $error("clear did not drop data alarm");
    a_good_buffer: assert property (fc_done && !frame_bad && link_active_state |=>
        q_ff.pend_valid)
        else $error("good frame not kept for reuse");

    // ----------------------------------------
    // covers
    // ----------------------------------------
    c_cycle_alarm: cover property (cyc_fault ##1 q_ff.cyc_alarm);
    c_data_commit: cover property (irq_edge && q_ff.pend_valid && !cyc_fault);
    c_bad_frame:   cover property (fc_done && frame_bad);
    c_subchk_run:  cover property (fc_done && fc_sub_zero && q_ff.sub_cnt == 4'h7);
    c_alarm_clear: cover property (q_ff.cyc_alarm ##1 !q_ff.cyc_alarm);

endmodule // cfeg_guard
`default_nettype wire

// >>> verif/cfeg_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// host side: cyclic frames and receive interrupts
// ----------------------------------------
module cfeg_host_model (
    // clock
    input  wire logic       hclk,
    // towards the guard
    output var  logic       rx_irq_start,
    output var  logic       rx_sof,
    output var  logic       rx_valid,
    output var  logic       rx_eof,
    output var  logic [7:0] rx_byte
);
    initial begin
        rx_irq_start = 1'b0;
        rx_sof       = 1'b0;
        rx_valid     = 1'b0;
        rx_eof       = 1'b0;
        rx_byte      = 8'h00;
    end

    // one interrupt; the next call rises exactly n cycles after this rise
    task automatic tick(input int n);
        rx_irq_start <= 1'b1;
        repeat (4) @(posedge hclk);
        rx_irq_start <= 1'b0;
        repeat (n - 4) @(posedge hclk);
    endtask

    // byte0 given, byte 16 bit 7 = sub, others base + index
    task automatic frame(input logic [7:0] b0, input int len, input logic sub, input logic [7:0] base);
        logic [7:0] b;
        b = 8'h00;
        for (int i = 0; i < len; i++) begin
            b = (i == 0) ? b0 : (i == 16) ? {sub, 7'h2a} : 8'(base + 8'(i));
            rx_valid <= 1'b1;
            rx_sof   <= (i == 0);
            rx_eof   <= (i == len - 1);
            rx_byte  <= b;
            @(posedge hclk);
        end
        rx_valid <= 1'b0;
        rx_sof   <= 1'b0;
        rx_eof   <= 1'b0;
        // released data never repeats the last byte, so stale reuse shows up
        rx_byte  <= ~b;
    endtask
endmodule // cfeg_host_model

`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "cfeg_defs.svh"

module tb;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        rx_irq_start;
    logic        rx_sof;
    logic        rx_valid;
    logic        rx_eof;
    logic [7:0]  rx_byte;
    logic [4:0]  station_identifier;
    logic        link_active_state;
    logic        link_synced;
    logic        cycle_alarm;
    logic        data_alarm;
    logic [31:0] cmd_word;
    logic        link_indicator;
    logic [1:0]  seen;
    int          fails;
    int          num_checks;

    // ----------------------------------------
    // clock, dut and host
    // ----------------------------------------
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    cfeg_guard #(.BLINK_CYCLES(8)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .rx_irq_start(rx_irq_start), .station_identifier(station_identifier),
        .rx_sof(rx_sof), .rx_valid(rx_valid), .rx_eof(rx_eof), .rx_byte(rx_byte),
        .link_active_state(link_active_state), .link_synced(link_synced), .cycle_alarm(cycle_alarm),
        .data_alarm(data_alarm), .cmd_word(cmd_word), .link_indicator(link_indicator)
    );

    cfeg_host_model u_host (
        .hclk(hclk), .rx_irq_start(rx_irq_start), .rx_sof(rx_sof), .rx_valid(rx_valid),
        .rx_eof(rx_eof), .rx_byte(rx_byte)
    );

    // ----------------------------------------
    // bus tasks and checks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // single word transfer; hready is the slave's own hreadyout
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h000000, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 32'h00000000, r);
        chk(r, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic complete_run;
        if (fails == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ----------------------------------------
    // watchdog: whole run needs well under 50000 cycles
    // ----------------------------------------
    initial begin
        repeat (50000) @(posedge hclk);
        fails++;
        complete_run;
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        fails = 0;
        num_checks = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h00000000;
        station_identifier = 5'h0b;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(`CFEG_OFS_CTRL, 32'h00000000);
        rd_chk(`CFEG_OFS_CYCLE, 32'(`CFEG_CYCLE_RST));
        rd_chk(`CFEG_OFS_STATUS, 32'h00000000);
        rd_chk(`CFEG_OFS_DATA, 32'h00000000);
        wr(8'h20, 32'hffffffff);
        rd_chk(8'h20, 32'h00000000);
        chk({31'h0, hresp}, 32'h00000000);
        wr(`CFEG_OFS_CYCLE, 32'h000003e8);
        rd_chk(`CFEG_OFS_CYCLE, 32'h000003e8);
        // link_active_state but not synchronized: irregular interrupts are ignored
        wr(`CFEG_OFS_CTRL, 32'h00000001);
        rd_chk(`CFEG_OFS_STATUS, 32'h00000001);
        u_host.tick(100);
        u_host.tick(3000);
        u_host.tick(100);
        cyc(8);
        chk({31'h0, cycle_alarm}, 32'h00000000);
        wr(`CFEG_OFS_CTRL, 32'h00000003);
        rd_chk(`CFEG_OFS_STATUS, 32'h00000003);
        // regular interrupts commit good frames; the last one is still pending
        u_host.tick(1000);
        fork
            u_host.tick(1000);
            u_host.frame(8'h0b, 4, 1'b0, 8'ha0);
        join
        fork
            u_host.tick(700);
            u_host.frame(8'h0b, 4, 1'b0, 8'hc0);
        join
        chk({31'h0, cycle_alarm}, 32'h00000000);
        chk(cmd_word, 32'ha3a2a10b);
        // short interval: cycle fault
        u_host.tick(10);
        chk({31'h0, cycle_alarm}, 32'h00000001);
        chk({31'h0, link_active_state}, 32'h00000000);
        chk({31'h0, link_synced}, 32'h00000000);
        chk(cmd_word, 32'ha3a2a10b);
        seen = 2'b00;
        for (int i = 0; i < 24; i++) begin
            @(posedge hclk);
            seen = seen | {link_indicator === 1'b1, link_indicator === 1'b0};
        end
        chk({30'h0, seen}, 32'h00000003);
        wr(`CFEG_OFS_CTRL, 32'h00000001);
        cyc(2);
        chk({31'h0, link_active_state}, 32'h00000000);
        wr(`CFEG_OFS_CTRL, 32'h00000100);
        cyc(3);
        chk({31'h0, cycle_alarm}, 32'h00000000);
        chk({31'h0, link_indicator}, 32'h00000000);
        wr(`CFEG_OFS_CTRL, 32'h00000001);
        rd_chk(`CFEG_OFS_STATUS, 32'h00000001);
        // cyclic data errors keep the link link_active_state
        u_host.frame(8'h0c, 4, 1'b0, 8'h10);
        cyc(4);
        chk({31'h0, data_alarm}, 32'h00000001);
        chk({31'h0, link_active_state}, 32'h00000001);
        chk(cmd_word, 32'ha3a2a10b);
        wr(`CFEG_OFS_CTRL, 32'h00000101);
        cyc(2);
        chk({31'h0, data_alarm}, 32'h00000000);
        u_host.frame(8'h8b, 4, 1'b0, 8'h10);
        cyc(4);
        chk({31'h0, data_alarm}, 32'h00000001);
        wr(`CFEG_OFS_CTRL, 32'h00000101);
        u_host.frame(8'h0b, 4, 1'b0, 8'h10);
        cyc(4);
        chk({31'h0, data_alarm}, 32'h00000000);
        // a new switch setting is compared after its synchroniser
        station_identifier <= 5'h0c;
        cyc(4);
        u_host.frame(8'h0c, 4, 1'b0, 8'h10);
        cyc(4);
        chk({31'h0, data_alarm}, 32'h00000000);
        u_host.frame(8'h0b, 4, 1'b0, 8'h10);
        cyc(4);
        chk({31'h0, data_alarm}, 32'h00000001);
        wr(`CFEG_OFS_CTRL, 32'h00000101);
        station_identifier <= 5'h0b;
        cyc(4);
        // 32-byte mode: sub-check low on eight frames in a row
        wr(`CFEG_OFS_CTRL, 32'h00000005);
        for (int i = 1; i <= 8; i++) begin
            u_host.frame(8'h0b, 17, 1'b0, 8'h10);
            cyc(4);
            chk({31'h0, data_alarm}, {31'h0, i == 8});
        end
        // mid-run reset: everything back to power-up values
        hresetn <= 1'b0;
        cyc(2);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk({31'h0, data_alarm}, 32'h00000000);
        rd_chk(`CFEG_OFS_CTRL, 32'h00000000);
        rd_chk(`CFEG_OFS_CYCLE, 32'(`CFEG_CYCLE_RST));
        complete_run;
    end
endmodule // tb

`default_nettype wire
